//--- pkg/aofr_pkg.sv
// constants and types for the acceleration output and fifo register block
package aofr_pkg;
  // sample geometry
  localparam int         AOFR_SW        = 14;
  localparam int         AOFR_HI_LSB    = 6;
  localparam int         AOFR_DEPTH     = 32;
  localparam int         AOFR_PW        = 5;
  localparam logic [5:0] AOFR_DEPTH_CNT = 6'h20;
  localparam logic [5:0] AOFR_CNT_ZERO  = 6'h00;
  // temperature scale in millidegrees per lsb, raw code passed through uncalibrated
  localparam int         AOFR_TEMP_MDEG = 960;

  // register offsets
  localparam logic [7:0] AOFR_A_STATUS  = 8'h00;
  localparam logic [7:0] AOFR_A_XH      = 8'h01;
  localparam logic [7:0] AOFR_A_XL      = 8'h02;
  localparam logic [7:0] AOFR_A_YH      = 8'h03;
  localparam logic [7:0] AOFR_A_YL      = 8'h04;
  localparam logic [7:0] AOFR_A_ZH      = 8'h05;
  localparam logic [7:0] AOFR_A_ZL      = 8'h06;
  localparam logic [7:0] AOFR_A_AFTER   = 8'h07;
  localparam logic [7:0] AOFR_A_SETUP   = 8'h09;
  localparam logic [7:0] AOFR_A_CFG     = 8'h0E;
  localparam logic [7:0] AOFR_A_MXH     = 8'h33;
  localparam logic [7:0] AOFR_A_MXL     = 8'h34;
  localparam logic [7:0] AOFR_A_MYH     = 8'h35;
  localparam logic [7:0] AOFR_A_MYL     = 8'h36;
  localparam logic [7:0] AOFR_A_MZH     = 8'h37;
  localparam logic [7:0] AOFR_A_MZL     = 8'h38;
  localparam logic [7:0] AOFR_A_MAFTER  = 8'h39;
  localparam logic [7:0] AOFR_A_TEMP    = 8'h51;

  // field positions and reset values
  localparam int         AOFR_F_HPF     = 4;
  localparam int         AOFR_F_DRDY    = 3;
  localparam logic [7:0] AOFR_CFG_MASK  = 8'h13;
  localparam logic [7:0] AOFR_SETUP_RST = 8'h00;
  localparam logic [7:0] AOFR_CFG_RST   = 8'h00;
  localparam logic [1:0] AOFR_HMS_HYB   = 2'h3;

  typedef enum logic [1:0] {
    AOFR_FM_OFF  = 2'b00,
    AOFR_FM_CIRC = 2'b01,
    AOFR_FM_FILL = 2'b10,
    AOFR_FM_TRIG = 2'b11
  } aofr_fmode_t;

  typedef struct packed {
    logic [AOFR_SW-1:0] x_sample;
    logic [AOFR_SW-1:0] y_sample;
    logic [AOFR_SW-1:0] z_sample;
  } aofr_sample_t;

  typedef struct packed {
    logic [15:0] x_mag;
    logic [15:0] y_mag;
    logic [15:0] z_mag;
  } aofr_mag_t;
endpackage

//--- verilog/aofr_top.sv
// acceleration output registers, sample fifo, range/filter config and temperature
//
// Contract
// - temperature register returns 8-bit signed code, 0.96 C per lsb, uncalibrated
// - temperature counts as valid only while magnetic sensor select is nonzero
// - each axis is 14-bit signed, high byte bits 13..6, low byte 5..0 left
// - fifo off: registers show current sample; fifo on: head of 32-deep buffer
// - fast read makes auto-increment skip low bytes; direct low reads still work
// - fifo off: hybrid auto-increment continues from acceleration z into the six magnetic bytes, only the three high bytes with fast read
// - fifo on: 0x01 reads head, direct reads of 0x02..0x06 give zero
// - addresses 0x00..0x06 form one auto-incrementing burst range
// - mode 00 off, 01 circular, 10 stop when full, 11 trigger
// - flush on disable, rate change, standby-to-active; disable clears flags and count
// - overflow flag set when sample count reaches 32
// - watermark flag when count at or above watermark; zero watermark disables
// - in trigger mode the watermark gives the pre-trigger sample count
// - mode writable while active; no direct switch between nonzero modes
// - count above watermark does not stop storing
// - samples stored at the system output data rate strobe
// - each fifo read returns oldest sample, removes it, count minus one
// - partial burst loses rest of sample; next read starts at next x
// - trigger mode circular until trigger, then fill to full, drop newest
// - filter enable one selects high-passed output, zero bypasses
// - range field 00 2g, 01 4g, 10 8g, 11 reserved
`timescale 1ns/10ps
module aofr_top (
  // clock and reset
  input  wire logic                  CORE_CLK_IN,
  input  wire logic                  RST_IN,
  // register port
  input  wire logic                  REG_START_IN,
  input  wire logic [7:0]            REG_ADDR_IN,
  input  wire logic                  REG_RD_IN,
  input  wire logic                  REG_WR_IN,
  input  wire logic [7:0]            REG_WDATA_IN,
  input  wire logic                  REG_STOP_IN,
  output logic      [7:0]            REG_RDATA_OUT,
  output logic                       REG_RVALID_OUT,
  // system control
  input  wire logic                  ACTIVE_IN,
  input  wire logic                  FAST_READ_IN,
  input  wire logic                  HYB_AUTOINC_IN,
  input  wire logic [1:0]            MAG_HMS_IN,
  input  wire logic                  ODR_CHANGE_IN,
  input  wire logic                  TRIGGER_IN,
  // samples
  input  wire logic                  SAMPLE_VALID_IN,
  input  wire aofr_pkg::aofr_sample_t SAMPLE_RAW_IN,
  input  wire aofr_pkg::aofr_sample_t SAMPLE_HPF_IN,
  input  wire aofr_pkg::aofr_mag_t   MAG_SAMPLE_IN,
  input  wire logic [7:0]            TEMP_IN,
  // status
  output logic      [1:0]            RANGE_SEL_OUT,
  output logic      [5:0]            FIFO_CNT_OUT,
  output logic                       FIFO_OVF_OUT,
  output logic                       FIFO_WMRK_OUT,
  output logic                       TEMP_VALID_OUT
);
  import aofr_pkg::*;

  aofr_sample_t     mem [AOFR_DEPTH];
  aofr_sample_t     cur_q;
  logic [7:0]       setup_q;
  logic [7:0]       cfg_q;
  logic [7:0]       ptr_q;
  logic [AOFR_PW-1:0] wr_q;
  logic [AOFR_PW-1:0] rd_q;
  logic [5:0]       cnt_q;
  logic [5:0]       cnt_d;
  logic             ovf_q;
  logic             wmrkf_q;
  logic             trig_q;
  logic             head_q;
  logic             drdy_q;
  logic             active_q;
  logic             temp_ok_q;
  logic [7:0]       rdata_q;
  logic             rvalid_q;

  // configuration decode
  aofr_fmode_t      fmode;
  logic [5:0]       wmrk;
  logic             fifo_on;
  logic             fast;
  logic             hyb_inc;
  logic             mode_wr;
  logic             cfg_wr;
  aofr_fmode_t      new_mode;
  logic             mode_ok;
  logic [7:0]       setup_d;

  assign fmode    = aofr_fmode_t'(setup_q[7:6]);
  assign wmrk     = setup_q[5:0];
  assign fifo_on  = fmode != AOFR_FM_OFF;
  assign fast     = FAST_READ_IN;
  assign hyb_inc  = (MAG_HMS_IN == AOFR_HMS_HYB) && HYB_AUTOINC_IN;
  assign mode_wr  = REG_WR_IN && (ptr_q == AOFR_A_SETUP);
  assign cfg_wr   = REG_WR_IN && (ptr_q == AOFR_A_CFG);
  assign new_mode = aofr_fmode_t'(REG_WDATA_IN[7:6]);
  // a write that jumps between two operating modes keeps the old mode
  assign mode_ok  = !(fifo_on && new_mode != AOFR_FM_OFF && new_mode != fmode);
  assign setup_d  = {mode_ok ? REG_WDATA_IN[7:6] : setup_q[7:6], REG_WDATA_IN[5:0]};

  // fifo control
  aofr_sample_t     in_sample;
  logic             flush;
  logic [5:0]       lim;
  logic             full;
  logic             push_req;
  logic             drop_oldest;
  logic             push;
  logic             drop_old;
  logic             rd_last;
  logic             pop;
  logic             wmrk_hit;

  assign in_sample   = cfg_q[AOFR_F_HPF] ? SAMPLE_HPF_IN : SAMPLE_RAW_IN;
  assign flush       = !fifo_on || ODR_CHANGE_IN || (ACTIVE_IN && !active_q);
  // before the trigger only the pre-trigger share of the buffer is kept
  assign lim         = (fmode == AOFR_FM_TRIG && !trig_q && wmrk != AOFR_CNT_ZERO)
                       ? wmrk : AOFR_DEPTH_CNT;
  assign full        = cnt_q >= lim;
  assign push_req    = SAMPLE_VALID_IN && ACTIVE_IN && fifo_on;
  assign drop_oldest = (fmode == AOFR_FM_CIRC) || (fmode == AOFR_FM_TRIG && !trig_q);
  assign push        = push_req && (!full || drop_oldest);
  // a read in the same cycle makes room, so the oldest is not also dropped; in the stop modes a full fifo still discards the new sample
  assign drop_old    = push && full && !pop;
  assign rd_last     = fifo_on && head_q && (ptr_q == (fast ? AOFR_A_ZH : AOFR_A_ZL));
  // a finished sample or an aborted burst both retire the head
  assign pop         = ((REG_RD_IN && rd_last) || (REG_STOP_IN && head_q))
                       && cnt_q != AOFR_CNT_ZERO && !flush;
  assign cnt_d       = flush ? AOFR_CNT_ZERO
                       : 6'(cnt_q + 6'(push) - 6'(pop) - 6'(drop_old));
  assign wmrk_hit    = (wmrk != AOFR_CNT_ZERO) && (cnt_d >= wmrk);

  // read data selection
  aofr_sample_t     src;
  logic             data_addr;
  logic             low_addr;
  logic [7:0]       acc_byte;
  logic [7:0]       rd_byte;
  logic [7:0]       ptr_nx;

  assign src       = fifo_on ? mem[rd_q] : cur_q;
  assign data_addr = (ptr_q >= AOFR_A_XH) && (ptr_q <= AOFR_A_ZL);
  assign low_addr  = data_addr && (ptr_q != AOFR_A_XH);

  always_comb begin
    case (ptr_q)
      AOFR_A_XH: acc_byte = src.x_sample[AOFR_SW-1 -: 8];
      AOFR_A_XL: acc_byte = {src.x_sample[AOFR_HI_LSB-1:0], 2'h0};
      AOFR_A_YH: acc_byte = src.y_sample[AOFR_SW-1 -: 8];
      AOFR_A_YL: acc_byte = {src.y_sample[AOFR_HI_LSB-1:0], 2'h0};
      AOFR_A_ZH: acc_byte = src.z_sample[AOFR_SW-1 -: 8];
      AOFR_A_ZL: acc_byte = {src.z_sample[AOFR_HI_LSB-1:0], 2'h0};
      default:   acc_byte = 8'h00;
    endcase
  end

  always_comb begin
    case (ptr_q)
      AOFR_A_STATUS: rd_byte = fifo_on ? {ovf_q, wmrkf_q, cnt_q}
                                       : 8'(drdy_q) << AOFR_F_DRDY;
      AOFR_A_SETUP:  rd_byte = setup_q;
      AOFR_A_CFG:    rd_byte = cfg_q & AOFR_CFG_MASK;
      AOFR_A_MXH:    rd_byte = MAG_SAMPLE_IN.x_mag[15:8];
      AOFR_A_MXL:    rd_byte = MAG_SAMPLE_IN.x_mag[7:0];
      AOFR_A_MYH:    rd_byte = MAG_SAMPLE_IN.y_mag[15:8];
      AOFR_A_MYL:    rd_byte = MAG_SAMPLE_IN.y_mag[7:0];
      AOFR_A_MZH:    rd_byte = MAG_SAMPLE_IN.z_mag[15:8];
      AOFR_A_MZL:    rd_byte = MAG_SAMPLE_IN.z_mag[7:0];
      AOFR_A_TEMP:   rd_byte = TEMP_IN;
      default: begin
        if (!data_addr) begin
          rd_byte = 8'h00;
        end else if (fifo_on && (cnt_q == AOFR_CNT_ZERO || (low_addr && !head_q))) begin
          rd_byte = 8'h00;
        end else begin
          rd_byte = acc_byte;
        end
      end
    endcase
  end

  // burst address walk
  always_comb begin
    ptr_nx = 8'(ptr_q + 8'h01);
    if (rd_last) begin
      ptr_nx = AOFR_A_XH;
    end else if (ptr_q == (fast ? AOFR_A_ZH : AOFR_A_ZL)) begin
      ptr_nx = hyb_inc ? AOFR_A_MXH : AOFR_A_AFTER;
    end else if (fast && (ptr_q == AOFR_A_XH || ptr_q == AOFR_A_YH ||
                          ptr_q == AOFR_A_MXH || ptr_q == AOFR_A_MYH)) begin
      ptr_nx = 8'(ptr_q + 8'h02);
    end else if (fast && ptr_q == AOFR_A_MZH) begin
      ptr_nx = AOFR_A_MAFTER;
    end
  end

  // register port
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ptr_q    <= AOFR_A_STATUS;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD_IN;
      if (REG_RD_IN) begin
        rdata_q <= rd_byte;
      end
      if (REG_START_IN) begin
        ptr_q <= REG_ADDR_IN;
      end else if (REG_RD_IN || REG_WR_IN) begin
        ptr_q <= ptr_nx;
      end
    end
  end

  // configuration registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      setup_q <= AOFR_SETUP_RST;
      cfg_q   <= AOFR_CFG_RST;
    end else begin
      if (mode_wr) begin
        setup_q <= setup_d;
      end
      if (cfg_wr) begin
        cfg_q <= REG_WDATA_IN & AOFR_CFG_MASK;
      end
    end
  end

  // fifo storage
  always_ff @(posedge CORE_CLK_IN) begin
    if (push && !flush) begin
      mem[wr_q] <= in_sample;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || flush) begin
      wr_q    <= '0;
      rd_q    <= '0;
      trig_q  <= 1'b0;
      ovf_q   <= 1'b0;
      wmrkf_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= AOFR_PW'(wr_q + 1'b1);
      end
      rd_q <= AOFR_PW'(rd_q + AOFR_PW'(pop) + AOFR_PW'(drop_old));
      if (TRIGGER_IN && fmode == AOFR_FM_TRIG) begin
        trig_q <= 1'b1;
      end
      if (cnt_d == AOFR_DEPTH_CNT) begin
        ovf_q <= 1'b1;
      end
      wmrkf_q <= wmrk_hit;
    end
  end

  // count, head tracking, current sample, data ready
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      cnt_q     <= AOFR_CNT_ZERO;
      head_q    <= 1'b0;
      cur_q     <= '0;
      drdy_q    <= 1'b0;
      active_q  <= 1'b0;
      temp_ok_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      active_q  <= ACTIVE_IN;
      temp_ok_q <= MAG_HMS_IN != 2'h0;
      if (REG_START_IN || REG_STOP_IN || pop || flush) begin
        head_q <= 1'b0;
      end else if (REG_RD_IN && fifo_on && ptr_q == AOFR_A_XH) begin
        head_q <= 1'b1;
      end
      if (SAMPLE_VALID_IN && ACTIVE_IN) begin
        cur_q <= in_sample;
      end
      // a new sample wins over the clearing read
      if (SAMPLE_VALID_IN && ACTIVE_IN) begin
        drdy_q <= 1'b1;
      end else if (REG_RD_IN && ptr_q == AOFR_A_XH) begin
        drdy_q <= 1'b0;
      end
    end
  end

  assign REG_RDATA_OUT  = rdata_q;
  assign REG_RVALID_OUT = rvalid_q;
  assign RANGE_SEL_OUT  = cfg_q[1:0];
  assign FIFO_CNT_OUT   = cnt_q;
  assign FIFO_OVF_OUT   = ovf_q;
  assign FIFO_WMRK_OUT  = wmrkf_q;
  assign TEMP_VALID_OUT = temp_ok_q;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_circ_full_push;
    fmode == AOFR_FM_CIRC && cnt_q == AOFR_DEPTH_CNT && push && !pop && !flush;
  endsequence
  sequence s_hyb_z_end;
    REG_RD_IN && !REG_START_IN && !fifo_on && !fast && hyb_inc && ptr_q == AOFR_A_ZL;
  endsequence

  cnt_range_a: assert property (cnt_q <= AOFR_DEPTH_CNT)
    else $error("fifo count above depth");
  ovf_flag_a: assert property (cnt_q == AOFR_DEPTH_CNT |-> ovf_q)
    else $error("overflow flag missing at full count");
  wmrk_flag_a: assert property (wmrk_hit && !flush |=> wmrkf_q)
    else $error("watermark flag not raised");
  flush_clear_a: assert property (flush |=> cnt_q == AOFR_CNT_ZERO && !ovf_q && !wmrkf_q)
    else $error("flush left state behind");
  pop_dec_a: assert property (pop && !push && !drop_old |=> cnt_q == $past(cnt_q) - 6'h01)
    else $error("read did not decrement count");
  fill_hold_a: assert property (fmode == AOFR_FM_FILL && cnt_q == AOFR_DEPTH_CNT && !pop
                                && !flush ##1 !flush |-> cnt_q == AOFR_DEPTH_CNT)
    else $error("stop mode accepted sample when full");
  circ_drop_a: assert property (s_circ_full_push |=>
                                cnt_q == AOFR_DEPTH_CNT && rd_q == AOFR_PW'($past(rd_q) + 1'b1))
    else $error("circular mode did not drop oldest");
  mode_lock_a: assert property (mode_wr && !mode_ok |=> setup_q[7:6] == $past(setup_q[7:6]))
    else $error("illegal mode switch taken");
  fast_skip_a: assert property (REG_RD_IN && !REG_START_IN && fast && !fifo_on
                                && ptr_q == AOFR_A_XH |=> ptr_q == AOFR_A_YH)
    else $error("fast read did not skip low byte");
  hyb_walk_a: assert property (s_hyb_z_end |=> ptr_q == AOFR_A_MXH)
    else $error("hybrid burst did not move to magnetic data");
  zero_low_a: assert property (REG_RD_IN && fifo_on && !head_q && low_addr
                               |=> REG_RVALID_OUT && REG_RDATA_OUT == 8'h00)
    else $error("direct low read in fifo mode not zero");
  temp_valid_a: assert property (##1 TEMP_VALID_OUT == ($past(MAG_HMS_IN) != 2'h0))
    else $error("temperature valid wrong");
endmodule

//--- dv/aofr_host.sv
// host model that reaches the block's registers through start, read, write and stop bursts
`timescale 1ns/10ps
module aofr_host (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic            start_out,
  output logic [7:0]      addr_out,
  output logic            rd_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out,
  output logic            stop_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  logic [7:0] rbuf [0:11];
  int         miss;

  initial begin
    start_out = 1'b0;
    addr_out  = 8'hA5;
    rd_out    = 1'b0;
    wr_out    = 1'b0;
    wdata_out = 8'h5A;
    stop_out  = 1'b0;
    miss      = 0;
  end

  // entered just after a rising edge, leaves just after one
  task automatic burst(input logic [7:0] a, input int n);
    start_out = 1'b1;
    addr_out  = a;
    @(posedge clk_in) #1;
    start_out = 1'b0;
    addr_out  = ~a;
    rd_out    = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in) #1;
      if (i == n - 1) rd_out = 1'b0;
      if (rvalid_in !== 1'b1) miss++;
      rbuf[i] = rdata_in;
    end
    // every burst is closed, so a partly read sample is retired here
    stop_out = 1'b1;
    @(posedge clk_in) #1;
    stop_out = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start_out = 1'b1;
    addr_out  = a;
    @(posedge clk_in) #1;
    start_out = 1'b0;
    addr_out  = ~a;
    wr_out    = 1'b1;
    wdata_out = d;
    @(posedge clk_in) #1;
    wr_out    = 1'b0;
    wdata_out = ~d;
    stop_out  = 1'b1;
    @(posedge clk_in) #1;
    stop_out  = 1'b0;
  endtask
endmodule

//--- dv/test_aofr_top.sv
// self-checking bench for the acceleration output and fifo register block
`timescale 1ns/10ps
module test_aofr_top;
  import aofr_pkg::*;
  localparam logic [41:0] HK = 42'h155_5555_5555;
  logic clk = 1'b0;
  logic rst, act, fast, hyb, odr, trig, vld, start, rd, wr, stop, rvalid, ovf, wmk, tval;
  logic [1:0] hms, rng;
  logic [5:0] cnt;
  logic [7:0] addr, wdata, rdata, tmp;
  aofr_sample_t raw, hpf, s;
  aofr_mag_t mag = '{x_mag: 16'hA1B2, y_mag: 16'hC3D4, z_mag: 16'hE5F6};
  int idx, base, n_errors, total_checks;

  always #20 clk = ~clk;

  function automatic aofr_sample_t smp(int i);
    return '{x_sample: 14'(i + 14'h0123), y_sample: 14'(3 * i + 14'h0A05),
             z_sample: 14'(14'h3F00 - i)};
  endfunction
  // sample lines carry junk outside the valid strobe
  assign raw = vld ? smp(idx) : ~smp(idx);
  assign hpf = raw ^ HK;

  aofr_top aofr_top_i (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_START_IN(start),
    .REG_ADDR_IN(addr), .REG_RD_IN(rd), .REG_WR_IN(wr), .REG_WDATA_IN(wdata),
    .REG_STOP_IN(stop), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .ACTIVE_IN(act),
    .FAST_READ_IN(fast), .HYB_AUTOINC_IN(hyb), .MAG_HMS_IN(hms), .ODR_CHANGE_IN(odr),
    .TRIGGER_IN(trig), .SAMPLE_VALID_IN(vld), .SAMPLE_RAW_IN(raw), .SAMPLE_HPF_IN(hpf),
    .MAG_SAMPLE_IN(mag), .TEMP_IN(tmp), .RANGE_SEL_OUT(rng), .FIFO_CNT_OUT(cnt),
    .FIFO_OVF_OUT(ovf), .FIFO_WMRK_OUT(wmk), .TEMP_VALID_OUT(tval));
  aofr_host aofr_host_i (.clk_in(clk), .start_out(start), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wdata), .stop_out(stop), .rdata_in(rdata), .rvalid_in(rvalid));

  function automatic logic [7:0] eb(aofr_sample_t v, int k);
    logic [13:0] a;
    a = (k < 2) ? v.x_sample : (k < 4) ? v.y_sample : v.z_sample;
    return k[0] ? {a[5:0], 2'b00} : a[13:6];
  endfunction
  function automatic logic [7:0] rb(int k);
    return aofr_host_i.rbuf[k];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_smp(input int off, input aofr_sample_t v);
    for (int k = 0; k < 6; k++) chk(rb(off + k), eb(v, k));
  endtask
  task automatic rd_b(input logic [7:0] a, input int n);
    aofr_host_i.burst(a, n);
  endtask
  task automatic push(input int n);
    vld = 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge clk) #1;
      idx++;
    end
    vld = 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic step;
    @(posedge clk) #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    n_errors++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    {act, fast, hyb, odr, trig, vld} = 6'h00;
    hms = 2'h0;
    idx = 0;
    tmp = 8'hE7;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd_b(AOFR_A_SETUP, 1);
    chk(rb(0), AOFR_SETUP_RST);
    rd_b(AOFR_A_CFG, 1);
    chk(rb(0), AOFR_CFG_RST);
    act = 1'b1;
    push(1);
    s = smp(idx - 1);
    rd_b(AOFR_A_STATUS, 7);
    chk(rb(0), 8'h08);
    chk_smp(1, s);
    fast = 1'b1;
    rd_b(AOFR_A_XH, 3);
    for (int k = 0; k < 3; k++) chk(rb(k), eb(s, 2 * k));
    rd_b(AOFR_A_XL, 1);
    chk(rb(0), eb(s, 1));
    hms = AOFR_HMS_HYB;
    hyb = 1'b1;
    rd_b(AOFR_A_XH, 6);
    for (int k = 0; k < 3; k++) chk(rb(3 + k), mag[47 - 16 * k -: 8]);
    fast = 1'b0;
    rd_b(AOFR_A_XH, 12);
    chk_smp(0, s);
    for (int k = 0; k < 6; k++) chk(rb(6 + k), mag[47 - 8 * k -: 8]);
    hyb = 1'b0;
    rd_b(AOFR_A_TEMP, 1);
    chk(rb(0), 8'hE7);
    tmp = 8'h18;
    rd_b(AOFR_A_TEMP, 1);
    chk(rb(0), 8'h18);
    chk(8'(tval), 8'h01);
    hms = 2'h0;
    step();
    chk(8'(tval), 8'h00);
    for (int r = 0; r < 4; r++) begin
      aofr_host_i.wr(AOFR_A_CFG, {6'h04, r[1:0]});
      chk(8'(rng), 8'(r));
    end
    rd_b(AOFR_A_CFG, 1);
    chk(rb(0), 8'h13);
    push(1);
    rd_b(AOFR_A_XH, 6);
    chk_smp(0, smp(idx - 1) ^ HK);
    aofr_host_i.wr(AOFR_A_CFG, 8'h00);
    push(1);
    rd_b(AOFR_A_XH, 6);
    chk_smp(0, smp(idx - 1));
    act = 1'b0;
    aofr_host_i.wr(AOFR_A_SETUP, 8'h44);
    push(1);
    act = 1'b1;
    step();
    chk(8'(cnt), 8'h00);
    base = idx;
    push(3);
    chk({wmk, 1'b0, cnt}, 8'h03);
    push(1);
    chk({wmk, 1'b0, cnt}, 8'h84);
    push(28);
    chk({ovf, 1'b0, cnt}, 8'hA0);
    push(2);
    chk(8'(cnt), 8'h20);
    rd_b(AOFR_A_XH, 6);
    chk_smp(0, smp(base + 2));
    chk(8'(cnt), 8'h1F);
    rd_b(AOFR_A_XL, 1);
    chk(rb(0), 8'h00);
    rd_b(AOFR_A_XH, 2);
    chk(8'(cnt), 8'h1E);
    rd_b(AOFR_A_XH, 1);
    chk(rb(0), eb(smp(base + 4), 0));
    rd_b(AOFR_A_STATUS, 1);
    chk(rb(0), {2'b11, 6'h1D});
    aofr_host_i.wr(AOFR_A_SETUP, 8'h84);
    rd_b(AOFR_A_SETUP, 1);
    chk(rb(0), 8'h44);
    aofr_host_i.wr(AOFR_A_SETUP, 8'h04);
    chk({ovf, wmk, cnt}, 8'h00);
    act = 1'b0;
    aofr_host_i.wr(AOFR_A_SETUP, 8'h80);
    act = 1'b1;
    step();
    base = idx;
    push(34);
    chk(8'(cnt), 8'h20);
    rd_b(AOFR_A_XH, 6);
    chk_smp(0, smp(base));
    odr = 1'b1;
    step();
    odr = 1'b0;
    step();
    chk({ovf, wmk, cnt}, 8'h00);
    rd_b(AOFR_A_XH, 6);
    chk(rb(0), 8'h00);
    chk(8'(cnt), 8'h00);
    act = 1'b0;
    aofr_host_i.wr(AOFR_A_SETUP, 8'h00);
    aofr_host_i.wr(AOFR_A_SETUP, 8'hC3);
    act = 1'b1;
    step();
    base = idx;
    push(5);
    chk(8'(cnt), 8'h03);
    rd_b(AOFR_A_XH, 6);
    chk_smp(0, smp(base + 2));
    trig = 1'b1;
    step();
    trig = 1'b0;
    push(40);
    chk(8'(cnt), 8'h20);
    rd_b(AOFR_A_XH, 6);
    chk_smp(0, smp(base + 3));
    fast = 1'b1;
    rd_b(AOFR_A_XH, 3);
    for (int k = 0; k < 3; k++) chk(rb(k), eb(smp(base + 4), 2 * k));
    chk(8'(cnt), 8'h1E);
    fast = 1'b0;
    act = 1'b0;
    step();
    act = 1'b1;
    step();
    step();
    chk(8'(cnt), 8'h00);
    chk(8'(aofr_host_i.miss), 8'h00);
    print_verdict();
  end
endmodule
